// File: dv/injection_props.sv
// port-level assertions for the fault injection countdown block
`timescale 1ns/1ps
module injection_props
   import fault_inject_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic [1:0]  timestamp_feature_field_i,
   input wire logic [1:0]  injection_feature_field_i,
   input wire logic        record_valid_i,
   input wire logic        syndrome_irq_enable_i,
   input wire logic        error_detected_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [11:0] reg_offset_i,
   input wire logic [63:0] reg_wdata_i,
   input wire logic [7:0]  reg_sel_i,
   input wire logic [1:0]  alias_kind_i,
   input wire logic [63:0] reg_rdata_o,
   input wire logic [63:0] alias_rdata_o,
   input wire logic        inject_o,
   input wire logic [7:0]  inject_type_o,
   input wire logic        syndrome_irq_o,
   input wire logic        capture_valid_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_rd(logic [11:0] off);
      reg_rd_i && reg_offset_i == off;
   endsequence
   property p_irq_gate; !syndrome_irq_enable_i |-> !syndrome_irq_o; endproperty
   property p_capture; capture_valid_o == (record_valid_i && timestamp_feature_field_i != feature_absent); endproperty
   property p_pulse; inject_o |=> !inject_o; endproperty
   property p_type; inject_o |-> inject_type_o != 8'h0; endproperty
   property p_absent; reg_rd_i && reg_offset_i[11] && injection_feature_field_i == feature_absent |=> reg_rdata_o == 64'h0;
   endproperty
   property p_cdn_rsv; s_rd(countdown_offset) |=> reg_rdata_o[63:32] == 32'h0; endproperty
   property p_ctl_rsv; s_rd(injection_ctrl_offset) |=> reg_rdata_o[63:32] == 32'h0 && reg_rdata_o[29:13] == 17'h0;
   endproperty
   property p_alias; $past(alias_kind_i) != alias_full |-> alias_rdata_o[63:32] == 32'h0; endproperty
   property p_clear;
      reg_wr_i && reg_offset_i == syndrome_three_offset && reg_wdata_i == 64'h0 && reg_sel_i == 8'h0
         && !error_detected_i |=> !syndrome_irq_o;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
   a_capture: assert property (p_capture) else $error("capture valid wrong");
   a_pulse: assert property (p_pulse) else $error("inject longer than one cycle");
   a_type: assert property (p_type) else $error("inject with no type");
   a_absent: assert property (p_absent) else $error("absent register not zero");
   a_cdn_rsv: assert property (p_cdn_rsv) else $error("countdown reserved bits set");
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("control reserved bits set");
   a_alias: assert property (p_alias) else $error("half alias upper bits set");
   a_clear: assert property (p_clear) else $error("irq kept after zero write");
endmodule
bind fault_injection_countdown injection_props u_props (.clk_i, .resetn_i, .timestamp_feature_field_i,
   .injection_feature_field_i, .record_valid_i, .syndrome_irq_enable_i, .error_detected_i, .reg_wr_i,
   .reg_rd_i, .reg_offset_i, .reg_wdata_i, .reg_sel_i, .alias_kind_i, .reg_rdata_o, .alias_rdata_o,
   .inject_o, .inject_type_o, .syndrome_irq_o, .capture_valid_o);

// File: dv/testbench.sv
// self-checking bench for the fault injection countdown block
`timescale 1ns/1ps
module testbench;
   import fault_inject_pkg::*;
   logic        clk_i = 0, resetn_i = 0, recovery_reset_i = 0, error_detected_i = 0, record_valid_i = 0;
   logic        status_syndrome_valid_i = 0, syndrome_irq_enable_i = 0, reg_wr_i = 0, reg_rd_i = 0;
   logic        alias_wr_i = 0, inject_o, inject_syndrome_valid_o, syndrome_irq_o, capture_valid_o;
   logic [1:0]  timestamp_feature_field_i = 2'h1, injection_feature_field_i = 2'h1, alias_kind_i = 2'h0;
   logic [11:0] reg_offset_i = 12'h0;
   logic [63:0] timestamp_i = 64'h0, reg_wdata_i = 64'h0, reg_rdata_o, alias_rdata_o;
   logic [7:0]  reg_sel_i = 8'h0, record_select_index_i = 8'h0, inject_type_o;
   logic [31:0] alias_wdata_i = 32'h0;
   int          bad_count = 0, samples_checked = 0, n;
   localparam logic [63:0] stamp = 64'h0123_4567_89ab_cdef;
   always #20 clk_i = ~clk_i;
   // short tick divide keeps every countdown within a few cycles
   fault_injection_countdown #(.tick_div(2)) dut (.clk_i, .resetn_i, .recovery_reset_i, .timestamp_feature_field_i,
      .injection_feature_field_i, .timestamp_i, .error_detected_i, .record_valid_i, .status_syndrome_valid_i,
      .syndrome_irq_enable_i, .reg_wr_i, .reg_rd_i, .reg_offset_i, .reg_wdata_i, .reg_sel_i, .record_select_index_i,
      .alias_wr_i, .alias_kind_i, .alias_wdata_i, .reg_rdata_o, .alias_rdata_o, .inject_o, .inject_type_o,
      .inject_syndrome_valid_o, .syndrome_irq_o, .capture_valid_o);
   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [11:0] off, logic [63:0] d);
      @(negedge clk_i);
      reg_offset_i = off;
      reg_wdata_i = d;
      reg_wr_i = 1;
      @(negedge clk_i);
      reg_wr_i = 0;
   endtask
   task automatic rd(string what, logic [11:0] off, logic [63:0] exp);
      @(negedge clk_i);
      reg_offset_i = off;
      reg_rd_i = 1;
      @(negedge clk_i);
      reg_rd_i = 0;
      check(what, reg_rdata_o, exp);
   endtask
   // gives up after 200 cycles, so a count of 200 means no injection
   task automatic wait_inject(output int c);
      c = 0;
      do begin
         @(negedge clk_i);
         c++;
      end while (inject_o !== 1'b1 && c < 200);
   endtask
   task automatic t_regs();
      rd("ctl reset", injection_ctrl_offset, 64'h0);
      wr(countdown_offset, 64'hffff_ffff_1234_5678);
      rd("cdn", countdown_offset, 64'h1234_5678);
      wr(injection_ctrl_offset, 64'hffff_ffff_7fff_ffff);
      rd("ctl", injection_ctrl_offset, 64'h4000_10fe);
      injection_feature_field_i = feature_absent;
      rd("ctl absent", injection_ctrl_offset, 64'h0);
      rd("cdn absent", countdown_offset, 64'h0);
      injection_feature_field_i = 2'h1;
   endtask
   task automatic t_oneshot();
      wr(countdown_offset, 64'h3);
      wr(injection_ctrl_offset, 64'h8000_1002);
      repeat (2) @(negedge clk_i);
      wr(injection_ctrl_offset, 64'h8000_1002);
      wait_inject(n);
      // three ticks two cycles apart; the first lands one or two cycles after the load
      check("delay", n == 5 || n == 6, 1'b1);
      check("type", inject_type_o, 8'h02);
      check("mv copy", inject_syndrome_valid_o, 1'b1);
      rd("cdn hidden", countdown_offset, 64'h3);
      wait_inject(n);
      check("stop at zero", n, 200);
      wr(injection_ctrl_offset, 64'h8000_0000);
      wait_inject(n);
      check("no type enabled", n, 200);
   endtask
   task automatic t_reload();
      wr(countdown_offset, 64'h2);
      // several types enabled: the lowest enabled one is raised
      wr(injection_ctrl_offset, 64'hc000_00c8);
      wait_inject(n);
      wait_inject(n);
      check("period", n, 4);
      check("type", inject_type_o, 8'h08);
      check("mv copy", inject_syndrome_valid_o, 1'b0);
      @(negedge clk_i);
      recovery_reset_i = 1;
      @(negedge clk_i);
      recovery_reset_i = 0;
      rd("ctl kept", injection_ctrl_offset, 64'hc000_00c8);
      rd("cdn kept", countdown_offset, 64'h2);
      wait_inject(n);
      check("runs after recovery", n <= 4, 1'b1);
      wr(injection_ctrl_offset, 64'h0);
      wait_inject(n);
      check("disabled", n, 200);
   endtask
   task automatic t_syndrome();
      @(negedge clk_i);
      timestamp_i = stamp;
      record_valid_i = 1;
      error_detected_i = 1;
      @(negedge clk_i);
      error_detected_i = 0;
      check("capture valid", capture_valid_o, 1'b1);
      rd("stamp", syndrome_three_offset, stamp);
      alias_kind_i = alias_high;
      repeat (2) @(negedge clk_i);
      check("high alias", alias_rdata_o, stamp[63:32]);
      alias_kind_i = alias_low;
      repeat (2) @(negedge clk_i);
      check("low alias", alias_rdata_o, stamp[31:0]);
      syndrome_irq_enable_i = 1;
      status_syndrome_valid_i = 1;
      wr(syndrome_three_offset, 64'h5);
      rd("held", syndrome_three_offset, stamp);
      check("irq", syndrome_irq_o, 1'b1);
      wr(syndrome_three_offset, 64'h0);
      check("irq cleared", syndrome_irq_o, 1'b0);
      rd("cleared", syndrome_three_offset, 64'h0);
      status_syndrome_valid_i = 0;
      alias_kind_i = alias_high;
      alias_wdata_i = 32'ha5;
      alias_wr_i = 1;
      @(negedge clk_i);
      alias_wr_i = 0;
      rd("alias write", syndrome_three_offset, 64'ha5_0000_0000);
      alias_kind_i = alias_low;
      alias_wdata_i = 32'h5a;
      alias_wr_i = 1;
      @(negedge clk_i);
      alias_wr_i = 0;
      alias_kind_i = alias_full;
      repeat (2) @(negedge clk_i);
      check("full alias", alias_rdata_o, 64'ha5_0000_005a);
      timestamp_feature_field_i = feature_absent;
      timestamp_i = ~stamp;
      error_detected_i = 1;
      @(negedge clk_i);
      error_detected_i = 0;
      check("capture valid off", capture_valid_o, 1'b0);
      rd("no capture", syndrome_three_offset, 64'ha5_0000_005a);
      timestamp_feature_field_i = 2'h1;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge clk_i);
      resetn_i = 1;
      t_regs();
      t_oneshot();
      t_reload();
      t_syndrome();
      complete_run();
   end
   // the tests need under 1000 cycles; four times that means a hang
   initial begin
      #(4000 * 40);
      bad_count++;
      complete_run();
   end
endmodule

// File: hdl/error_type_picker.sv
// picks one enabled error type, lowest enabled bit first
`timescale 1ns/1ps
module error_type_picker (
   input  wire logic [7:0] enables_i,
   output logic [7:0]      pick_o
);
   always_comb begin
      pick_o = 8'h0;
      for (int i = 7; i >= 1; i--) begin
         if (enables_i[i]) begin
            pick_o = 8'h0;
            pick_o[i] = 1'b1;
         end
      end
      // corrected-error field is two bits: keep its code whole
      if (pick_o[7] || pick_o[6]) begin
         pick_o[7:6] = enables_i[7:6];
      end
   end
endmodule

// File: hdl/fault_inject_pkg.sv
// constants for the pseudo-fault injection countdown block
package fault_inject_pkg;
   localparam logic [11:0] syndrome_three_offset  = 12'h038;
   localparam logic [11:0] injection_ctrl_offset  = 12'h808;
   localparam logic [11:0] countdown_offset       = 12'h810;
   localparam int          countdown_enable_bit   = 31;
   localparam int          auto_reload_bit        = 30;
   localparam int          syndrome_override_bit  = 12;
   localparam int          type_enable_msb        = 7;
   localparam logic [7:0]  type_enable_mask       = 8'hfe;
   localparam logic [1:0]  feature_absent         = 2'h0;
   localparam logic [1:0]  alias_full             = 2'h0;
   localparam logic [1:0]  alias_low              = 2'h1;
   localparam logic [1:0]  alias_high             = 2'h2;
   localparam int          tick_divide            = 25;
   localparam logic [63:0] record_reset_value     = 64'h0;
endpackage

// File: hdl/fault_injection_countdown.sv
// pseudo-fault injection countdown and third syndrome register of one record
// Contract
// - writing zero to the syndrome register is always accepted and clears it, unless a detection lands in the same cycle with timestamps supported
// - writing zero to syndrome fields withdraws any interrupt request they raise
// - with timestamps supported, the syndrome register captures detection time
// - timestamp fills all 64 bits, meaningful only while record valid is 1
// - timestamp and reload value survive error-recovery reset
// - low alias reaches bits 31:0, high alias bits 63:32 of selected record
// - multi-error syndrome stays writable so software can reset it
// - latest-error syndrome ignores non-zero writes while status syndrome valid is 1
// - interrupt syndrome disabled at cold reset, enabled by software later
// - injection registers exist only with injection feature on first record
// - counter loads reload value on enable write or zero with auto-reload
// - counter decrements by one per tick while enabled and non-zero
// - reaching zero generates one enabled error type
// - live count never readable; reads give the reload value
// - enable bit 31 runs or stops the counter; writing 1 reloads
// - enable clears on cold reset, kept across error-recovery reset
// - auto-reload bit 30 stops at zero when clear, reloads when set
// - auto-reload and override read zero when unsupported
// - override bit 12 copied into status syndrome valid on injection
// - override reads one when node always records syndrome
// - reserved bits of both injection registers read as zero
// - per-type enables choose which types may be generated; zero suppresses
`timescale 1ns/1ps
module fault_injection_countdown
   import fault_inject_pkg::*;
#(
   parameter int          record_index      = 0,
   parameter logic        first_record      = 1'b1,
   parameter logic        has_auto_reload   = 1'b1,
   parameter logic        has_override      = 1'b1,
   parameter logic        override_forced   = 1'b0,
   parameter int          tick_div          = tick_divide
) (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        recovery_reset_i,
   input  wire logic [1:0]  timestamp_feature_field_i,
   input  wire logic [1:0]  injection_feature_field_i,
   input  wire logic [63:0] timestamp_i,
   input  wire logic        error_detected_i,
   input  wire logic        record_valid_i,
   input  wire logic        status_syndrome_valid_i,
   input  wire logic        syndrome_irq_enable_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [11:0] reg_offset_i,
   input  wire logic [63:0] reg_wdata_i,
   input  wire logic [7:0]  reg_sel_i,
   input  wire logic [7:0]  record_select_index_i,
   input  wire logic        alias_wr_i,
   input  wire logic [1:0]  alias_kind_i,
   input  wire logic [31:0] alias_wdata_i,
   output logic [63:0]      reg_rdata_o,
   output logic [63:0]      alias_rdata_o,
   output logic             inject_o,
   output logic [7:0]       inject_type_o,
   output logic             inject_syndrome_valid_o,
   output logic             syndrome_irq_o,
   output logic             capture_valid_o
);
   logic [63:0] capture_time_value_r;
   logic [63:0] capture_time_value_nxt;
   logic [31:0] countdown_reload_value_r;
   logic [31:0] countdown_reload_value_nxt;
   logic [31:0] counter_r;
   logic [31:0] counter_nxt;
   logic        countdown_enable_r;
   logic        countdown_enable_nxt;
   logic        auto_reload_r;
   logic        auto_reload_nxt;
   logic        override_r;
   logic        override_nxt;
   logic [7:0]  type_enable_r;
   logic [7:0]  type_enable_nxt;
   logic        inject_nxt;
   logic [7:0]  inject_type_nxt;
   logic        inject_mv_nxt;
   logic        tick;
   logic [7:0]  picked;
   logic        inj_present;
   logic        ts_present;
   logic        wr_syn;
   logic        wr_ctl;
   logic        wr_cdn;
   logic        alias_hit;
   logic [63:0] syn_wdata;
   logic [63:0] ctl_read;
   logic [63:0] cdn_read;
   logic        override_read;
   logic        zero_tick;
   logic        rd_hit;
   logic [63:0] reg_rdata_nxt;
   logic [63:0] alias_rdata_nxt;

   // one clock only: the countdown rate is a one-cycle enable from a divider
   tick_divider #(.divide(tick_div)) u_tick (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .tick_o   (tick)
   );

   // bit 0 is the overflow flag and never names a type, so the mask drops it
   error_type_picker u_pick (
      .enables_i (type_enable_r & type_enable_mask),
      .pick_o    (picked)
   );

   assign inj_present = (injection_feature_field_i != feature_absent) && first_record;
   assign ts_present  = (timestamp_feature_field_i != feature_absent);
   assign alias_hit   = (record_select_index_i == 8'(record_index));

   // register-port and alias writes to the syndrome register merge here
   always_comb begin
      wr_ctl    = reg_wr_i && (reg_sel_i == 8'(record_index)) && (reg_offset_i == injection_ctrl_offset)
                  && inj_present;
      wr_cdn    = reg_wr_i && (reg_sel_i == 8'(record_index)) && (reg_offset_i == countdown_offset) && inj_present;
      wr_syn    = 1'b0;
      syn_wdata = capture_time_value_r;
      if (reg_wr_i && (reg_sel_i == 8'(record_index)) && (reg_offset_i == syndrome_three_offset)) begin
         wr_syn    = 1'b1;
         syn_wdata = reg_wdata_i;
      end else if (alias_wr_i && alias_hit) begin
         wr_syn = 1'b1;
         unique case (alias_kind_i)
            alias_low:  syn_wdata = {capture_time_value_r[63:32], alias_wdata_i};
            alias_high: syn_wdata = {alias_wdata_i, capture_time_value_r[31:0]};
            default:    wr_syn = 1'b0;
         endcase
      end
   end

   always_comb begin
      capture_time_value_nxt = capture_time_value_r;
      // a new detection wins over a software write in the same cycle when timestamps are supported;
      // a zero write clears even while status valid is set, so a request can always be withdrawn
      if (error_detected_i && ts_present) begin
         capture_time_value_nxt = timestamp_i;
      end else if (wr_syn && (syn_wdata == record_reset_value)) begin
         capture_time_value_nxt = record_reset_value;
      end else if (wr_syn && !status_syndrome_valid_i) begin
         capture_time_value_nxt = syn_wdata;
      end
   end

   assign syndrome_irq_o  = syndrome_irq_enable_i && (capture_time_value_r != record_reset_value);
   assign capture_valid_o = record_valid_i && ts_present;

   // the counter stands at one on a live tick: this tick brings it to zero, or back to the reload value with auto-reload
   assign zero_tick = countdown_enable_r && tick && (counter_r == 32'h1);

   // software-visible control fields
   always_comb begin
      countdown_reload_value_nxt = countdown_reload_value_r;
      countdown_enable_nxt       = countdown_enable_r;
      auto_reload_nxt            = auto_reload_r;
      override_nxt               = override_r;
      type_enable_nxt            = type_enable_r;
      if (wr_cdn) begin
         countdown_reload_value_nxt = reg_wdata_i[31:0];
      end
      if (wr_ctl) begin
         countdown_enable_nxt = reg_wdata_i[countdown_enable_bit];
         auto_reload_nxt      = reg_wdata_i[auto_reload_bit] && has_auto_reload;
         override_nxt         = reg_wdata_i[syndrome_override_bit] && has_override;
         type_enable_nxt      = reg_wdata_i[type_enable_msb:0];
      end
   end

   // error generation counter; a software load beats a tick in the same cycle
   always_comb begin
      counter_nxt = counter_r;
      if (countdown_enable_r && tick && (counter_r != 32'h0)) begin
         counter_nxt = counter_r - 32'h1;
         if (zero_tick && auto_reload_r) begin
            counter_nxt = countdown_reload_value_r;
         end
      end
      if (wr_ctl && reg_wdata_i[countdown_enable_bit]) begin
         counter_nxt = countdown_reload_value_r;
      end
   end

   // injection pulse, with the type and override captured alongside it
   always_comb begin
      inject_nxt      = zero_tick && (picked != 8'h0);
      inject_type_nxt = inject_type_o;
      inject_mv_nxt   = inject_syndrome_valid_o;
      if (zero_tick) begin
         inject_type_nxt = picked;
         inject_mv_nxt   = override_read;
      end
      // recovery reset drops a pending pulse but leaves the count running
      if (recovery_reset_i) begin
         inject_nxt = 1'b0;
      end
   end

   // a node that always records syndrome shows the override stuck at one
   assign override_read = override_forced ? 1'b1 : override_r;

   // syndrome capture is kept through recovery reset; cold reset gives zero
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         capture_time_value_r <= 64'h0;
      end else begin
         capture_time_value_r <= capture_time_value_nxt;
      end
   end

   // only the enable must clear on cold reset; the rest start at zero so early reads are defined
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         countdown_enable_r       <= 1'b0;
         counter_r                <= 32'h0;
         countdown_reload_value_r <= 32'h0;
         auto_reload_r            <= 1'b0;
         override_r               <= 1'b0;
         type_enable_r            <= 8'h0;
      end else begin
         countdown_enable_r       <= countdown_enable_nxt;
         counter_r                <= counter_nxt;
         countdown_reload_value_r <= countdown_reload_value_nxt;
         auto_reload_r            <= auto_reload_nxt;
         override_r               <= override_nxt;
         type_enable_r            <= type_enable_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         inject_o                <= 1'b0;
         inject_type_o           <= 8'h0;
         inject_syndrome_valid_o <= 1'b0;
      end else begin
         inject_o                <= inject_nxt;
         inject_type_o           <= inject_type_nxt;
         inject_syndrome_valid_o <= inject_mv_nxt;
      end
   end

   always_comb begin
      ctl_read = 64'h0;
      cdn_read = 64'h0;
      if (inj_present) begin
         ctl_read[countdown_enable_bit]  = countdown_enable_r;
         ctl_read[auto_reload_bit]       = auto_reload_r;
         ctl_read[syndrome_override_bit] = override_read;
         ctl_read[type_enable_msb:0]     = type_enable_r & type_enable_mask;
         cdn_read[31:0]                  = countdown_reload_value_r;
      end
   end

   assign rd_hit = reg_rd_i && (reg_sel_i == 8'(record_index));

   // memory-mapped read data is zero outside a read so no stale word lingers
   always_comb begin
      reg_rdata_nxt = 64'h0;
      if (rd_hit) begin
         unique case (reg_offset_i)
            syndrome_three_offset: reg_rdata_nxt = capture_time_value_r;
            injection_ctrl_offset: reg_rdata_nxt = ctl_read;
            countdown_offset:      reg_rdata_nxt = cdn_read;
            default:               reg_rdata_nxt = 64'h0;
         endcase
      end
   end

   // the aliases follow the selected record continuously, one cycle late
   always_comb begin
      alias_rdata_nxt = 64'h0;
      if (alias_hit) begin
         unique case (alias_kind_i)
            alias_full: alias_rdata_nxt = capture_time_value_r;
            alias_low:  alias_rdata_nxt = {32'h0, capture_time_value_r[31:0]};
            alias_high: alias_rdata_nxt = {32'h0, capture_time_value_r[63:32]};
            default:    alias_rdata_nxt = 64'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 64'h0;
      end else begin
         reg_rdata_o <= reg_rdata_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         alias_rdata_o <= 64'h0;
      end else begin
         alias_rdata_o <= alias_rdata_nxt;
      end
   end
endmodule

// File: hdl/tick_divider.sv
// divider producing the countdown tick enable
`timescale 1ns/1ps
module tick_divider #(
   parameter int divide = 25
) (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   output logic      tick_o
);
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic        tick_nxt;
   always_comb begin
      tick_nxt = (cnt_r == 16'(divide - 1));
      cnt_nxt  = tick_nxt ? 16'h0 : cnt_r + 16'h1;
   end
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_r  <= 16'h0;
         tick_o <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_o <= tick_nxt;
      end
   end
endmodule
